// ===== verilog/cmd_source_pkg.sv
// Constants for the command source selector: register map,
// field positions, reset values and the source-mode codes.
// Assumes a 32-bit classic Wishbone register bus.
package cmd_source_pkg;

    // Source-mode codes
    typedef enum logic [1:0] {
        MODE_TERMINAL = 2'h0,
        MODE_BUS      = 2'h1,
        MODE_AND      = 2'h2,
        MODE_OR       = 2'h3
    } mode_type;

    ////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_BUSCMD  = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;

    ////////////////////////////////////////////////////////////////
    // Mode register fields
    localparam int MODE_DIR_POS    = 0;
    localparam int MODE_SETUP_POS  = 2;
    localparam int MODE_PRESET_POS = 4;

    // Bus command register fields
    localparam int BUS_DIR_POS     = 0;
    localparam int BUS_SETUP_POS   = 1;
    localparam int BUS_PRESET_POS  = 3;

    // Status register fields
    localparam int STAT_CCW_POS    = 0;
    localparam int STAT_SETUP_POS  = 1;
    localparam int STAT_PRESET_POS = 4;

    ////////////////////////////////////////////////////////////////
    // Reset values
    localparam mode_type   RST_DIR_MODE    = MODE_TERMINAL;
    localparam mode_type   RST_SETUP_MODE  = MODE_OR;
    localparam mode_type   RST_PRESET_MODE = MODE_OR;
    localparam logic [2:0] RST_NUMBER      = 3'h1;
    localparam logic [1:0] RST_PAIR        = 2'h0;
    localparam logic [31:0] RST_DATA       = 32'h0000_0000;

endpackage : cmd_source_pkg

// ===== verilog/command_source_selector.sv
// Command source selector: merges terminal and serial-bus commands
// for rotation direction, setup selection and preset selection.
// Assumes terminal inputs already synchronous to ref_clk and a
// classic Wishbone master on the register port.
//
// Summary of operation
// - Direction from terminal, bus, AND or OR per mode; 1 means counter-clockwise.
// - Setup number is the merged two-bit code plus one.
// - AND mode merges bus and terminal pairs bitwise with AND.
// - OR mode merges bus and terminal pairs bitwise with OR.
// - Preset selection merges the same way under its own mode, one to four.
// - Mode codes 0 terminal, 1 bus, 2 AND, 3 OR; setup/preset reset OR.
// - Direction mode resets to terminal only.
// - Bus-only mode ignores the terminal input entirely.
`timescale 1ns/100ps

module command_source_selector (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Digital input terminals
    input  wire logic        directionInputTerminal,
    input  wire logic [1:0]  setupTerminal,
    input  wire logic [1:0]  presetTerminal,
    // Merged commands
    output logic             directionCcw,
    output logic [2:0]       setupNumber,
    output logic [2:0]       presetNumber
);

    ////////////////////////////////////////////////////////////////
    // Merge of a terminal pair and a bus pair under a source mode
    function automatic logic [1:0] mergePair(
        input cmd_source_pkg::mode_type mode,
        input logic [1:0]               term,
        input logic [1:0]               bus
    );
        logic [1:0] res;
        res = term;
        unique case (mode)
            cmd_source_pkg::MODE_TERMINAL: res = term;
            cmd_source_pkg::MODE_BUS:      res = bus;
            cmd_source_pkg::MODE_AND:      res = term & bus;
            cmd_source_pkg::MODE_OR:       res = term | bus;
        endcase
        return res;
    endfunction : mergePair

    // Selection number is code plus one
    function automatic logic [2:0] toNumber(input logic [1:0] code);
        return {1'b0, code} + 3'h1;
    endfunction : toNumber

    ////////////////////////////////////////////////////////////////
    // Register and output state
    cmd_source_pkg::mode_type dirMode_reg;
    cmd_source_pkg::mode_type dirMode_next;
    cmd_source_pkg::mode_type setupMode_reg;
    cmd_source_pkg::mode_type setupMode_next;
    cmd_source_pkg::mode_type presetMode_reg;
    cmd_source_pkg::mode_type presetMode_next;
    logic        busDir_reg;
    logic        busDir_next;
    logic [1:0]  busSetup_reg;
    logic [1:0]  busSetup_next;
    logic [1:0]  busPreset_reg;
    logic [1:0]  busPreset_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        ccw_reg;
    logic        ccw_next;
    logic [2:0]  setupNum_reg;
    logic [2:0]  setupNum_next;
    logic [2:0]  presetNum_reg;
    logic [2:0]  presetNum_next;

    logic        busReq;
    logic        busWrite;
    logic [1:0]  dirPair;
    logic [31:0] modeWord;
    logic [31:0] busWord;
    logic [31:0] statusWord;

    assign dat_o        = dat_reg;
    assign ack_o        = ack_reg;
    assign directionCcw = ccw_reg;
    assign setupNumber  = setupNum_reg;
    assign presetNumber = presetNum_reg;

    ////////////////////////////////////////////////////////////////
    // Read-back words; unused bits read as zero
    always_comb begin
        modeWord   = cmd_source_pkg::RST_DATA;
        busWord    = cmd_source_pkg::RST_DATA;
        statusWord = cmd_source_pkg::RST_DATA;
        modeWord[cmd_source_pkg::MODE_DIR_POS +: 2]    = dirMode_reg;
        modeWord[cmd_source_pkg::MODE_SETUP_POS +: 2]  = setupMode_reg;
        modeWord[cmd_source_pkg::MODE_PRESET_POS +: 2] = presetMode_reg;
        busWord[cmd_source_pkg::BUS_DIR_POS]           = busDir_reg;
        busWord[cmd_source_pkg::BUS_SETUP_POS +: 2]    = busSetup_reg;
        busWord[cmd_source_pkg::BUS_PRESET_POS +: 2]   = busPreset_reg;
        statusWord[cmd_source_pkg::STAT_CCW_POS]          = ccw_reg;
        statusWord[cmd_source_pkg::STAT_SETUP_POS +: 3]   = setupNum_reg;
        statusWord[cmd_source_pkg::STAT_PRESET_POS +: 3]  = presetNum_reg;
    end

    ////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, for one cycle
    assign busReq   = cyc_i & stb_i;
    // Write lands on the edge at which the master sees ack
    assign busWrite = busReq & we_i & ack_reg & sel_i[0];

    always_comb begin
        ack_next        = busReq & ~ack_reg;
        dat_next        = cmd_source_pkg::RST_DATA;
        dirMode_next    = dirMode_reg;
        setupMode_next  = setupMode_reg;
        presetMode_next = presetMode_reg;
        busDir_next     = busDir_reg;
        busSetup_next   = busSetup_reg;
        busPreset_next  = busPreset_reg;
        if (busReq && !ack_reg && !we_i) begin
            unique case (adr_i)
                cmd_source_pkg::OFS_MODE:   dat_next = modeWord;
                cmd_source_pkg::OFS_BUSCMD: dat_next = busWord;
                cmd_source_pkg::OFS_STATUS: dat_next = statusWord;
                default:                    dat_next = cmd_source_pkg::RST_DATA;
            endcase
        end
        // Numeric codes only; every two-bit value is a legal mode
        if (busWrite && adr_i == cmd_source_pkg::OFS_MODE) begin
            dirMode_next    = cmd_source_pkg::mode_type'(
                dat_i[cmd_source_pkg::MODE_DIR_POS +: 2]);
            setupMode_next  = cmd_source_pkg::mode_type'(
                dat_i[cmd_source_pkg::MODE_SETUP_POS +: 2]);
            presetMode_next = cmd_source_pkg::mode_type'(
                dat_i[cmd_source_pkg::MODE_PRESET_POS +: 2]);
        end
        if (busWrite && adr_i == cmd_source_pkg::OFS_BUSCMD) begin
            busDir_next    = dat_i[cmd_source_pkg::BUS_DIR_POS];
            busSetup_next  = dat_i[cmd_source_pkg::BUS_SETUP_POS +: 2];
            busPreset_next = dat_i[cmd_source_pkg::BUS_PRESET_POS +: 2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg        <= 1'b0;
            dat_reg        <= cmd_source_pkg::RST_DATA;
            dirMode_reg    <= cmd_source_pkg::RST_DIR_MODE;
            setupMode_reg  <= cmd_source_pkg::RST_SETUP_MODE;
            presetMode_reg <= cmd_source_pkg::RST_PRESET_MODE;
            busDir_reg     <= 1'b0;
            busSetup_reg   <= cmd_source_pkg::RST_PAIR;
            busPreset_reg  <= cmd_source_pkg::RST_PAIR;
        end else begin
            ack_reg        <= ack_next;
            dat_reg        <= dat_next;
            dirMode_reg    <= dirMode_next;
            setupMode_reg  <= setupMode_next;
            presetMode_reg <= presetMode_next;
            busDir_reg     <= busDir_next;
            busSetup_reg   <= busSetup_next;
            busPreset_reg  <= busPreset_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command merge, registered so outputs never glitch downstream
    always_comb begin
        dirPair = mergePair(dirMode_reg,
                            {1'b0, directionInputTerminal},
                            {1'b0, busDir_reg});
        ccw_next       = dirPair[0];
        setupNum_next  = toNumber(mergePair(setupMode_reg,
                            setupTerminal, busSetup_reg));
        presetNum_next = toNumber(mergePair(presetMode_reg,
                            presetTerminal, busPreset_reg));
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ccw_reg       <= 1'b0;
            setupNum_reg  <= cmd_source_pkg::RST_NUMBER;
            presetNum_reg <= cmd_source_pkg::RST_NUMBER;
        end else begin
            ccw_reg       <= ccw_next;
            setupNum_reg  <= setupNum_next;
            presetNum_reg <= presetNum_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence wbRequest;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence wbSingleAck;
        ack_o ##1 !ack_o;
    endsequence

    property wbAnswer;
        wbRequest |=> wbSingleAck;
    endproperty

    a_wb_ack_once: assert property (wbAnswer)
        else $error("bus ack not a single pulse one cycle after request");

    a_reset_mode_values: assert property (
        $rose(rst_n) |-> (dirMode_reg == cmd_source_pkg::MODE_TERMINAL
            && setupMode_reg == cmd_source_pkg::MODE_OR
            && presetMode_reg == cmd_source_pkg::MODE_OR))
        else $error("mode registers not at reset codes");

    a_dir_terminal_only: assert property (
        ($past(dirMode_reg) == cmd_source_pkg::MODE_TERMINAL)
        |-> (directionCcw == $past(directionInputTerminal)))
        else $error("direction does not follow terminal");

    a_dir_bus_only: assert property (
        ($past(dirMode_reg) == cmd_source_pkg::MODE_BUS)
        |-> (directionCcw == $past(busDir_reg)))
        else $error("direction does not follow bus bit");

    a_dir_logic_and: assert property (
        ($past(dirMode_reg) == cmd_source_pkg::MODE_AND)
        |-> (directionCcw ==
             ($past(directionInputTerminal) && $past(busDir_reg))))
        else $error("direction AND merge wrong");

    a_setup_terminal_sel: assert property (
        ($past(setupMode_reg) == cmd_source_pkg::MODE_TERMINAL)
        |-> (setupNumber == {1'b0, $past(setupTerminal)} + 3'h1))
        else $error("setup number not terminal code plus one");

    a_setup_logic_and: assert property (
        ($past(setupMode_reg) == cmd_source_pkg::MODE_AND)
        |-> (setupNumber ==
             {1'b0, $past(setupTerminal) & $past(busSetup_reg)} + 3'h1))
        else $error("setup AND merge wrong");

    a_setup_logic_or: assert property (
        ($past(setupMode_reg) == cmd_source_pkg::MODE_OR)
        |-> (setupNumber ==
             {1'b0, $past(setupTerminal) | $past(busSetup_reg)} + 3'h1))
        else $error("setup OR merge wrong");

    a_preset_bus_sel: assert property (
        ($past(presetMode_reg) == cmd_source_pkg::MODE_BUS)
        |-> (presetNumber == {1'b0, $past(busPreset_reg)} + 3'h1))
        else $error("preset number not bus code plus one");

    a_out_one_cycle: assert property (
        // Mode must already stand one cycle, else output held a bus value
        (dirMode_reg == cmd_source_pkg::MODE_TERMINAL)
        && $stable(dirMode_reg) && $changed(directionInputTerminal)
        ##1 (dirMode_reg == cmd_source_pkg::MODE_TERMINAL)
        |-> $changed(directionCcw))
        else $error("direction did not follow terminal after one cycle");

endmodule : command_source_selector

// ===== tb/terminal_model.sv
// Far-side model: digital input terminal levels and the mode word
// that a serial master programs. Bench sets requests after an edge.
`timescale 1ns/100ps

module terminal_model (
    // Requests from the bench
    input  wire logic [4:0]               levelReq,
    input  wire cmd_source_pkg::mode_type dirMode,
    input  wire cmd_source_pkg::mode_type setupMode,
    input  wire cmd_source_pkg::mode_type presetMode,
    // Towards the block
    output logic                          directionInputTerminal,
    output logic [1:0]                    setupTerminal,
    output logic [1:0]                    presetTerminal,
    output logic [31:0]                   modeWord
);
    // Plain levels, no bounce
    assign {presetTerminal, setupTerminal, directionInputTerminal} = levelReq;
    // Numeric codes only, never display text
    assign modeWord = {26'h000_0000, presetMode, setupMode, dirMode};
endmodule : terminal_model

// ===== tb/tb.sv
// Bench for the command source selector: Wishbone master tasks,
// terminal model, exhaustive merge sweep. One clock, 250 MHz.
`timescale 1ns/100ps

module tb;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  selReq = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic [4:0]  levelReq = 5'h00;
    logic        dTerm;
    logic [1:0]  sTerm;
    logic [1:0]  pTerm;
    logic [31:0] modeWord;
    logic        dirCcw;
    logic [2:0]  setupNum;
    logic [2:0]  presetNum;
    logic [31:0] q;
    int          error_cnt = 0;
    int          compares = 0;
    cmd_source_pkg::mode_type dirMode = cmd_source_pkg::MODE_TERMINAL;
    cmd_source_pkg::mode_type setupMode = cmd_source_pkg::MODE_OR;
    cmd_source_pkg::mode_type presetMode = cmd_source_pkg::MODE_OR;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    terminal_model partner (.levelReq(levelReq), .dirMode(dirMode), .setupMode(setupMode),
        .presetMode(presetMode), .directionInputTerminal(dTerm), .setupTerminal(sTerm),
        .presetTerminal(pTerm), .modeWord(modeWord));

    command_source_selector dut (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .directionInputTerminal(dTerm), .setupTerminal(sTerm), .presetTerminal(pTerm),
        .directionCcw(dirCcw), .setupNumber(setupNum), .presetNumber(presetNum));

    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Called just after a rising edge; holds the request until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= selReq;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (ack !== 1'b1) begin
            error_cnt++;
            results();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge ref_clk);
    endtask : bus

    function automatic logic [1:0] merge(input int m, input logic [1:0] t, input logic [1:0] b);
        case (m)
            0: merge = t;
            1: merge = b;
            2: merge = t & b;
            default: merge = t | b;
        endcase
    endfunction : merge

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({dirCcw, setupNum, presetNum}, 7'b0_001_001);
        rst_n <= 1'b1;
        bus(1'b0, cmd_source_pkg::OFS_MODE, 32'h0000_0000);
        chk(q, 32'h0000_003C);
    endtask : t_reset

    // Every mode against every terminal/bus pair; bus pairs are the
    // terminal pairs swapped, so all sixteen combinations are seen
    task automatic t_merge();
        logic [6:0] e;
        logic [3:0] b;
        logic [1:0] d;
        for (int m = 0; m < 4; m++) begin
            dirMode <= cmd_source_pkg::mode_type'(2'(m));
            setupMode <= cmd_source_pkg::mode_type'(2'(m));
            presetMode <= cmd_source_pkg::mode_type'(2'(m));
            @(posedge ref_clk);
            bus(1'b1, cmd_source_pkg::OFS_MODE, modeWord);
            for (int v = 0; v < 16; v++) begin
                b = 4'(v);
                levelReq <= {b[3:2], b[1:0], b[0]};
                bus(1'b1, cmd_source_pkg::OFS_BUSCMD, {27'h000_0000, b[1:0], b[3:2], b[1]});
                @(posedge ref_clk);
                d = merge(m, {1'b0, b[0]}, {1'b0, b[1]});
                e[0] = d[0];
                e[3:1] = {1'b0, merge(m, b[1:0], b[3:2])} + 3'h1;
                e[6:4] = {1'b0, merge(m, b[3:2], b[1:0])} + 3'h1;
                chk({dirCcw, setupNum, presetNum}, {e[0], e[3:1], e[6:4]});
                bus(1'b0, cmd_source_pkg::OFS_STATUS, 32'h0000_0000);
                chk(q, {25'h000_0000, e});
            end
        end
    endtask : t_merge

    // One cycle from terminal change to output
    task automatic t_latency();
        bus(1'b1, cmd_source_pkg::OFS_BUSCMD, 32'h0000_0000);
        levelReq <= 5'h00;
        repeat (2) @(posedge ref_clk);
        levelReq <= 5'h1F;
        @(posedge ref_clk);
        chk({dirCcw, setupNum, presetNum}, 7'b0_001_001);
        @(posedge ref_clk);
        chk({dirCcw, setupNum, presetNum}, 7'b1_100_100);
    endtask : t_latency

    // Terminals low, so any leaked bus bit would show in the status word
    task automatic t_refuse();
        levelReq <= 5'h00;
        bus(1'b0, 8'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b1, cmd_source_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        selReq = 4'hE;
        bus(1'b1, cmd_source_pkg::OFS_BUSCMD, 32'hFFFF_FFFF);
        selReq = 4'hF;
        bus(1'b0, cmd_source_pkg::OFS_BUSCMD, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b0, cmd_source_pkg::OFS_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0012);
        bus(1'b0, cmd_source_pkg::OFS_MODE, 32'h0000_0000);
        chk(q, 32'h0000_003F);
    endtask : t_refuse

    initial begin
        repeat (10) @(posedge ref_clk);
        t_reset();
        t_merge();
        t_latency();
        t_refuse();
        results();
    end
endmodule : tb
